// >>> shared/sepc_pkg.sv
// Purpose: shared constants and types for the serial memory pin control block
// Assumes: one 10 MHz system clock; all pins arrive asynchronously
// Notes: program time is held in ms and converted to cycles here
package sepc_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int PROG_TIME_MS = 5;
    // longest time, so the count rounds down
    localparam int PROG_CYCLES = (CLK_HZ / MS_PER_S) * PROG_TIME_MS;
    localparam int PROG_W = 16;
    localparam int BYTE_W = 8;
    localparam int BIT_W = 3;
    localparam int BUF_DEPTH = 2;
    localparam int PIN_N = 4;
    localparam logic [BIT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [PROG_W-1:0] PROG_ZERO = 16'h0000;
    localparam logic [PROG_W-1:0] PROG_ONE = 16'h0001;

    typedef struct packed
    {
        logic csN;
        logic sck;
        logic si;
        logic wpN;
    } sepc_pins_t;

    typedef struct packed
    {
        logic [BYTE_W-1:0] data;
        logic first;
    } sepc_rxword_t;

    typedef enum logic [1:0]
    {
        ST_STANDBY = 2'h0,
        ST_SELECTED = 2'h1,
        ST_PROGRAM = 2'h3
    } sepc_state_t;

endpackage

// >>> src/sepc_buf.sv
// Purpose: two-entry shifting buffer with valid and ready on both sides
// Assumes: head entry is always slot 0
// Notes: inReady is low whenever the last slot is occupied
`timescale 1ns/1ns
`default_nettype none
module sepc_buf
    import sepc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire sepc_pkg::sepc_rxword_t inData,
    input wire logic inValid,
    output logic inReady,
    output sepc_pkg::sepc_rxword_t outData,
    output logic outValid,
    input wire logic outReady
);
    import sepc_pkg::*;

    logic [BUF_DEPTH-1:0] valid_q;
    sepc_rxword_t data_q [BUF_DEPTH];
    logic [BUF_DEPTH:0] validExt;
    logic [BUF_DEPTH:0] prevExt;
    logic [BUF_DEPTH-1:0] shV;
    logic push;
    logic pop;

    assign pop = outValid && outReady;
    assign push = inValid && inReady;
    assign inReady = !valid_q[BUF_DEPTH-1];
    assign outValid = valid_q[0];
    assign outData = data_q[0];
    assign validExt = {1'b0, valid_q};
    assign prevExt = {shV, 1'b1};

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < BUF_DEPTH; i++)
        begin : g_slot
            sepc_rxword_t shD;
            logic wrHere;
            if (i < BUF_DEPTH - 1)
            begin : g_mid
                assign shD = pop ? data_q[i+1] : data_q[i];
            end
            else
            begin : g_end
                assign shD = data_q[i];
            end
            assign shV[i] = pop ? validExt[i+1] : valid_q[i];
            assign wrHere = push && !shV[i] && prevExt[i];
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    valid_q[i] <= 1'b0;
                    data_q[i] <= '0;
                end
                else
                begin
                    valid_q[i] <= shV[i] || wrHere;
                    data_q[i] <= wrHere ? inData : shD;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> src/sepc_top.sv
// Purpose: pin-level select, shift and program-cycle control of a serial memory
// Assumes: pins are asynchronous and sampled by clk; sck is far slower than clk
// Notes: the command decoder outside flags write and status-write sequences
`timescale 1ns/1ns
`default_nettype none
module sepc_top
    import sepc_pkg::*;
#(
    parameter int PROG_LEN = PROG_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire sepc_pkg::sepc_pins_t pinIn,
    output logic soOut,
    output logic soOeN,
    input wire logic protectPinEnable,
    input wire logic seqIsWrite,
    input wire logic seqIsStatusWrite,
    input wire logic [7:0] txByte,
    output logic txTaken,
    output sepc_pkg::sepc_rxword_t rxWord,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxBufFull,
    output logic rxOverrun,
    output logic progStart,
    output logic progBusy,
    output logic statusWriteRefused,
    output logic standby
);
    import sepc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    sepc_pins_t sync1_q;
    sepc_pins_t sync2_q;
    sepc_pins_t prev_q;

    genvar p;
    generate
        for (p = 0; p < PIN_N; p++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    sync1_q[p] <= 1'b1;
                    sync2_q[p] <= 1'b1;
                    prev_q[p] <= 1'b1;
                end
                else
                begin
                    sync1_q[p] <= pinIn[p];
                    sync2_q[p] <= sync1_q[p];
                    prev_q[p] <= sync2_q[p];
                end
            end
        end
    endgenerate

    logic csN, sck, si, wpN;
    logic csRise, csFall, sckRise, sckFall;
    assign csN = sync2_q.csN;
    assign sck = sync2_q.sck;
    assign si = sync2_q.si;
    assign wpN = sync2_q.wpN;
    assign csRise = csN && !prev_q.csN;
    assign csFall = !csN && prev_q.csN;
    assign sckRise = sck && !prev_q.sck;
    assign sckFall = !sck && prev_q.sck;

    ////////////////////////////////////////////////////////////////////////
    // selection
    logic armed_q;
    logic selected;
    assign selected = !csN && armed_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            armed_q <= 1'b0;
        else if (!csN)
            armed_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // input shifting
    logic [BIT_W-1:0] bitCnt_q;
    logic [BYTE_W-1:0] shiftIn_q;
    logic gotByte_q, firstByte_q;
    logic inStep, byteDone, bufInReady;
    sepc_rxword_t pushWord;

    assign inStep = selected && sckRise;
    assign byteDone = inStep && (bitCnt_q == BIT_LAST);
    assign pushWord = '{data: {shiftIn_q[BYTE_W-2:0], si}, first: firstByte_q};

    always_ff @(posedge clk)
    begin
        if (!nrst || !selected)
        begin
            bitCnt_q <= BIT_FIRST;
            shiftIn_q <= BYTE_ZERO;
            gotByte_q <= 1'b0;
            firstByte_q <= 1'b1;
        end
        else if (inStep)
        begin
            bitCnt_q <= bitCnt_q + 3'h1;
            shiftIn_q <= {shiftIn_q[BYTE_W-2:0], si};
            gotByte_q <= gotByte_q || byteDone;
            firstByte_q <= firstByte_q && !byteDone;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst || csFall)
            rxOverrun <= 1'b0;
        else if (byteDone && !bufInReady)
            rxOverrun <= 1'b1;
    end

    sepc_buf u_buf
    (
        .clk(clk),
        .nrst(nrst),
        .inData(pushWord),
        .inValid(byteDone),
        .inReady(bufInReady),
        .outData(rxWord),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rxBufFull <= 1'b0;
        else
            rxBufFull <= !bufInReady;
    end

    ////////////////////////////////////////////////////////////////////////
    // output shifting
    logic [BYTE_W-1:0] shiftOut_q;
    logic outStep, outLoad;
    assign outStep = selected && sckFall;
    assign outLoad = outStep && (bitCnt_q == BIT_FIRST);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            shiftOut_q <= BYTE_ZERO;
            soOut <= 1'b0;
            txTaken <= 1'b0;
            soOeN <= 1'b1;
        end
        else
        begin
            txTaken <= outLoad;
            soOeN <= !selected;
            if (outLoad)
            begin
                shiftOut_q <= {txByte[BYTE_W-2:0], 1'b0};
                soOut <= txByte[BYTE_W-1];
            end
            else if (outStep)
            begin
                shiftOut_q <= {shiftOut_q[BYTE_W-2:0], 1'b0};
                soOut <= shiftOut_q[BYTE_W-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write protect and commit
    logic cancel_q;
    logic cancelSet, commitSeen, commitOk;
    sepc_state_t state_q;
    sepc_state_t state_d;
    assign cancelSet = selected && seqIsStatusWrite && protectPinEnable && !wpN;
    assign commitSeen = csRise && (state_q == ST_SELECTED) && gotByte_q && (bitCnt_q == BIT_FIRST) && seqIsWrite;
    assign commitOk = commitSeen && !(cancel_q && seqIsStatusWrite);

    always_ff @(posedge clk)
    begin
        if (!nrst)
            cancel_q <= 1'b0;
        else if (cancelSet)
            cancel_q <= 1'b1;
        else if (csFall)
            cancel_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // program state machine
    logic [PROG_W-1:0] progCnt_q;
    logic progEnd;
    assign progEnd = (state_q == ST_PROGRAM) && (progCnt_q == PROG_W'(PROG_LEN - 1));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY:
                if (selected)
                    state_d = ST_SELECTED;
            ST_SELECTED:
                if (commitOk)
                    state_d = ST_PROGRAM;
                else if (csN)
                    state_d = ST_STANDBY;
            ST_PROGRAM:
                if (progEnd)
                    state_d = selected ? ST_SELECTED : ST_STANDBY;
            default:
                state_d = ST_STANDBY;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_STANDBY;
            progCnt_q <= PROG_ZERO;
            progStart <= 1'b0;
            progBusy <= 1'b0;
            statusWriteRefused <= 1'b0;
            standby <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            progCnt_q <= (state_q == ST_PROGRAM) ? progCnt_q + PROG_ONE : PROG_ZERO;
            progStart <= commitOk;
            progBusy <= (state_d == ST_PROGRAM);
            statusWriteRefused <= commitSeen && !commitOk;
            standby <= (state_d == ST_STANDBY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_sel;
        @(posedge clk) disable iff (!nrst) sckRise && !selected |=> bitCnt_q == BIT_FIRST;
    endproperty
    a_sel: assert property (p_sel) else $error("clock counted while deselected");

    property p_desel;
        @(posedge clk) disable iff (!nrst) csN |=> bitCnt_q == BIT_FIRST && !gotByte_q;
    endproperty
    a_desel: assert property (p_desel) else $error("partial bits kept after deselect");

    property p_finish;
        @(posedge clk) disable iff (!nrst) progBusy |-> !standby;
    endproperty
    a_finish: assert property (p_finish) else $error("standby during program cycle");

    property p_tristate;
        @(posedge clk) disable iff (!nrst) !selected |=> soOeN;
    endproperty
    a_tristate: assert property (p_tristate) else $error("output driven while deselected");

    property p_commit;
        @(posedge clk) disable iff (!nrst) commitOk |=> progStart && progBusy ##1 !progStart && progBusy;
    endproperty
    a_commit: assert property (p_commit) else $error("program cycle not started");

    property p_bound;
        @(posedge clk) disable iff (!nrst) progBusy |-> progCnt_q < PROG_W'(PROG_LEN);
    endproperty
    a_bound: assert property (p_bound) else $error("program cycle too long");

    property p_armed;
        @(posedge clk) disable iff (!nrst) !armed_q |-> !rxValid && bitCnt_q == BIT_FIRST;
    endproperty
    a_armed: assert property (p_armed) else $error("sequence accepted before first select");

    property p_outEdge;
        @(posedge clk) disable iff (!nrst) !$stable(soOut) |-> $past(sckFall);
    endproperty
    a_outEdge: assert property (p_outEdge) else $error("output changed without falling clock");

    property p_capture;
        @(posedge clk) disable iff (!nrst) inStep |=> shiftIn_q[0] == $past(si) || bitCnt_q == BIT_FIRST;
    endproperty
    a_capture: assert property (p_capture) else $error("input bit not captured");

    property p_refuse;
        @(posedge clk) disable iff (!nrst) commitSeen && cancel_q && seqIsStatusWrite |=> statusWriteRefused && !progBusy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("protected status write went ahead");

    property p_noEffect;
        @(posedge clk) disable iff (!nrst) $fell(wpN) && progBusy && !progEnd |=> progBusy;
    endproperty
    a_noEffect: assert property (p_noEffect) else $error("pin fall disturbed program cycle");

    property p_ignorePin;
        @(posedge clk) disable iff (!nrst) !protectPinEnable && csFall |=> !cancel_q || cancelSet;
    endproperty
    a_ignorePin: assert property (p_ignorePin) else $error("pin used while enable clear");

    property p_pinHigh;
        @(posedge clk) disable iff (!nrst) cancelSet |-> !wpN && protectPinEnable;
    endproperty
    a_pinHigh: assert property (p_pinHigh) else $error("cancel without low pin");

    c_byte: cover property (@(posedge clk) disable iff (!nrst) byteDone);
    c_prog: cover property (@(posedge clk) disable iff (!nrst) progStart);
    c_refused: cover property (@(posedge clk) disable iff (!nrst) statusWriteRefused);
    c_full: cover property (@(posedge clk) disable iff (!nrst) rxBufFull);

endmodule
`default_nettype wire

// >>> test/sepc_host.sv
// Purpose: host model driving select, serial clock and data pins
// Assumes: serial clock idles high, bits go msb first, half period is four system clocks
// Notes: pins move only at the falling edge of the system clock
`timescale 1ns/1ns
`default_nettype none
module sepc_host
(
    input wire logic clk,
    input wire logic soLine,
    output logic csN,
    output logic sck,
    output logic si
);
    initial
    begin
        csN = 1'h1;
        sck = 1'h1;
        si = 1'h0;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // select and give the device time to arm before the first clock
    task automatic sel();
        @(negedge clk);
        csN = 1'h0;
        half();
    endtask

    // raising select commits a finished write; released data shows the inverse
    task automatic desel();
        half();
        csN = 1'h1;
        si = ~si;
    endtask

    // n bits out on si, the device answer is taken at each rising clock
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sck = 1'h0;
            si = tx[i];
            half();
            sck = 1'h1;
            rx[i] = soLine;
            half();
        end
    endtask
endmodule
`default_nettype wire

// >>> test/sepc_top_tb_top.sv
// Purpose: self-checking bench for the serial memory pin control block
// Assumes: host model drives select, clock and data pins, the bench drives wpN and plays the command decoder
// Notes: a short program length keeps the run brief
`timescale 1ns/1ns
`default_nettype none
module sepc_top_tb_top;
    import sepc_pkg::*;
    localparam int PLEN = 20;
    typedef struct packed
    {
        logic wpN;
        logic pinEn;
        logic wr;
        logic sw;
        logic commit;
        logic refuse;
        logic [7:0] tx;
        logic [7:0] rxd;
    } sepc_row_t;
    sepc_row_t rows [6] = '{
        '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'hA5, 8'h3C},
        '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 8'h5A, 8'h01},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 8'hFF, 8'h80},
        '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 8'h00, 8'h7E},
        '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'hC3, 8'h96},
        '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h81, 8'h42}};
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic wpN = 1'h1;
    logic pinEn = 1'h0;
    logic wr = 1'h0;
    logic sw = 1'h0;
    logic rxReady = 1'h0;
    logic [7:0] txByte = 8'h00;
    logic csN, sck, si, soOut, soOeN, rxValid, rxBufFull, rxOverrun, progStart, progBusy, swRefused, standby;
    logic txTaken;
    sepc_rxword_t rxWord;
    sepc_pins_t pins;
    wire soLine;
    int error_cnt = 0;
    int samples_checked = 0;
    int txCnt = 0;

    assign pins = {csN, sck, si, wpN};
    // the bus floats while the device releases it
    assign soLine = soOeN ? 1'bz : soOut;

    always #50 clk = ~clk;

    // one load pulse per byte started on the link
    always @(negedge clk) txCnt += int'(txTaken === 1'h1);

    sepc_host host_u (.clk(clk), .soLine(soLine), .csN(csN), .sck(sck), .si(si));

    sepc_top #(.PROG_LEN(PLEN)) dut_u (.clk(clk), .nrst(nrst), .pinIn(pins), .soOut(soOut), .soOeN(soOeN),
        .protectPinEnable(pinEn), .seqIsWrite(wr), .seqIsStatusWrite(sw), .txByte(txByte), .txTaken(txTaken),
        .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady), .rxBufFull(rxBufFull), .rxOverrun(rxOverrun),
        .progStart(progStart), .progBusy(progBusy), .statusWriteRefused(swRefused), .standby(standby));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // counts pulses, busy cycles and busy cycles spent in standby
    task automatic run(input int n, output int st, output int rf, output int bc, output int bad);
        st = 0;
        rf = 0;
        bc = 0;
        bad = 0;
        repeat (n)
        begin
            @(negedge clk);
            st += int'(progStart === 1'h1);
            rf += int'(swRefused === 1'h1);
            bc += int'(progBusy === 1'h1);
            bad += int'(progBusy === 1'h1 && standby !== 1'h0);
        end
    endtask

    task automatic pop(input logic [7:0] d, input logic f);
        @(negedge clk);
        chk1("rxValid", 1'h1, rxValid);
        chk8("rxData", d, rxWord.data);
        chk1("rxFirst", f, rxWord.first);
        rxReady = 1'h1;
        @(negedge clk);
        rxReady = 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        int st, rf, bc, bad;
        logic [7:0] rx;
        repeat (3) @(negedge clk);
        chk1("soOeN", 1'h1, soOeN);
        chk1("standby", 1'h1, standby);
        chk1("progBusy", 1'h0, progBusy);
        nrst = 1'h1;
        foreach (rows[k])
        begin
            wpN = rows[k].wpN;
            pinEn = rows[k].pinEn;
            wr = rows[k].wr;
            sw = rows[k].sw;
            txByte = rows[k].tx;
            host_u.sel();
            chk1("soOeN", 1'h0, soOeN);
            host_u.xfer(rows[k].rxd, 8, rx);
            chk8("soByte", rows[k].tx, rx);
            chk8("txTaken", 8'(k + 1), 8'(txCnt));
            host_u.desel();
            run(PLEN + 12, st, rf, bc, bad);
            chk1("progStart", rows[k].commit, st == 1);
            chk1("refused", rows[k].refuse, rf == 1);
            chk8("busyLen", rows[k].commit ? 8'(PLEN) : 8'h00, 8'(bc));
            chk1("standby", 1'h1, standby);
            chk1("soOeN", 1'h1, soOeN);
            pop(rows[k].rxd, 1'h1);
        end
        // reselect and drop the protect pin while programming runs
        wpN = 1'h1;
        pinEn = 1'h1;
        wr = 1'h1;
        sw = 1'h1;
        host_u.sel();
        host_u.xfer(8'h3C, 8, rx);
        host_u.desel();
        fork
            run(PLEN + 16, st, rf, bc, bad);
            begin
                repeat (5) @(negedge clk);
                wpN = 1'h0;
                host_u.sel();
                host_u.xfer(8'h00, 2, rx);
                host_u.desel();
            end
        join
        chk8("busyLen", 8'(PLEN), 8'(bc));
        chk1("progStart", 1'h1, st == 1);
        chk1("standbyInBusy", 1'h0, bad != 0);
        chk1("standby", 1'h1, standby);
        pop(8'h3C, 1'h1);
        // three bytes into a stalled two-entry buffer
        wr = 1'h0;
        sw = 1'h0;
        wpN = 1'h1;
        host_u.sel();
        host_u.xfer(8'h11, 8, rx);
        host_u.xfer(8'h22, 8, rx);
        host_u.xfer(8'h33, 8, rx);
        host_u.desel();
        repeat (4) @(negedge clk);
        chk1("rxBufFull", 1'h1, rxBufFull);
        chk1("rxOverrun", 1'h1, rxOverrun);
        pop(8'h11, 1'h1);
        pop(8'h22, 1'h0);
        @(negedge clk);
        chk1("rxValid", 1'h0, rxValid);
        // partial byte, then clocks while deselected
        wr = 1'h1;
        host_u.sel();
        host_u.xfer(8'hF0, 5, rx);
        host_u.desel();
        run(12, st, rf, bc, bad);
        chk1("progStart", 1'h0, st != 0);
        host_u.xfer(8'h0F, 8, rx);
        @(negedge clk);
        chk1("rxValid", 1'h0, rxValid);
        chk8("txTaken", 8'h0C, 8'(txCnt));
        wr = 1'h0;
        host_u.sel();
        host_u.xfer(8'h99, 8, rx);
        host_u.desel();
        pop(8'h99, 1'h1);
        stop_test();
    end
endmodule
`default_nettype wire
